// ---- hdl/gwl_irq_ctrl.sv ----
// grouped interrupt request, vectoring and wake-up logic with ahb-lite registers
`timescale 1ns/10ps
`default_nettype none

module gwl_irq_ctrl #(
  parameter int PC_W = 14
) (
  input  wire logic                        hclk,
  input  wire logic                        hresetn,
  input  wire logic                        hsel,
  input  wire logic [31:0]                 haddr,
  input  wire logic [1:0]                  htrans,
  input  wire logic                        hwrite,
  input  wire logic [2:0]                  hsize,
  input  wire logic [31:0]                 hwdata,
  input  wire logic                        hready,
  output logic      [31:0]                 hrdata,
  output logic                             hreadyout,
  output logic                             hresp,
  input  wire logic [PC_W-1:0]             pc_value,
  input  wire logic                        stack_full,
  input  wire logic                        interrupt_exit,
  input  wire logic                        subroutine_exit,
  input  wire logic                        nvm_write_done,
  input  wire logic [gwl_pkg::NUM_TMR-1:0] tmr_match_a,
  input  wire logic [gwl_pkg::NUM_TMR-1:0] tmr_match_p,
  output logic                             stack_push,
  output logic      [PC_W-1:0]             push_pc,
  output logic                             pc_load,
  output logic      [PC_W-1:0]             vector_addr,
  output logic                             irq_busy,
  output logic                             wake
);
  import gwl_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [GRP_W-1:0] pick_lowest(input logic [NUM_GRP-1:0] pend);
    logic [GRP_W-1:0] idx;
    idx = GRP_W'(NUM_GRP - 1);
    for (int g = NUM_GRP - 1; g >= 0; g--) begin
      if (pend[g]) begin
        idx = GRP_W'(g);
      end
    end
    return idx;
  endfunction

  function automatic logic [PC_W-1:0] grp_vector(input logic [GRP_W-1:0] g);
    logic [PC_W-1:0] v;
    v = PC_W'(VEC_GRP0);
    if (g == 2'h1) begin
      v = PC_W'(VEC_GRP1);
    end else if (g == 2'h2) begin
      v = PC_W'(VEC_GRP2);
    end
    return v;
  endfunction

  function automatic logic [SRC_W-1:0] grp_mask(input int g);
    logic [SRC_W-1:0] m;
    m = GRP0_MASK;
    if (g == 1) begin
      m = GRP1_MASK;
    end else if (g == 2) begin
      m = GRP2_MASK;
    end
    return m;
  endfunction

  // ----------------------------------------------------------------
  // ahb-lite slave
  // ----------------------------------------------------------------
  logic              acc;
  logic              wr_pend_q;
  logic              rd_pend_q;
  logic [REG_AW-1:0] addr_q;
  logic [31:0]       hrdata_q;
  logic [31:0]       rd_mux;
  logic              we_ctrl;
  logic              we_src_flag;
  logic              we_src_en;
  logic              we_grp_flag;
  logic              we_grp_en;

  assign acc = hsel && htrans[1] && hready;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q    <= '0;
    end else begin
      wr_pend_q <= acc && hwrite;
      rd_pend_q <= acc && !hwrite;
      if (acc) begin
        addr_q <= haddr[REG_AW-1:0];
      end
    end
  end

  assign we_ctrl     = wr_pend_q && (addr_q == ADDR_CTRL);
  assign we_src_flag = wr_pend_q && (addr_q == ADDR_SRC_FLAG);
  assign we_src_en   = wr_pend_q && (addr_q == ADDR_SRC_EN);
  assign we_grp_flag = wr_pend_q && (addr_q == ADDR_GRP_FLAG);
  assign we_grp_en   = wr_pend_q && (addr_q == ADDR_GRP_EN);

  // reads take one wait state so that a write just before is visible
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= '0;
    end else if (rd_pend_q) begin
      hrdata_q <= rd_mux;
    end
  end

  assign hrdata    = hrdata_q;
  assign hreadyout = !rd_pend_q;
  assign hresp     = HRESP_OKAY;

  // ----------------------------------------------------------------
  // source request flags
  // ----------------------------------------------------------------
  logic [SRC_W-1:0]   src_evt;
  logic [SRC_W-1:0]   src_flags;
  logic [SRC_W-1:0]   src_rise;
  logic [SRC_W-1:0]   src_en_q;
  logic [NUM_GRP-1:0] grp_set;
  logic [NUM_GRP-1:0] grp_clr;
  logic [NUM_GRP-1:0] grp_flags;
  logic [NUM_GRP-1:0] grp_rise;
  logic [NUM_GRP-1:0] grp_en_q;
  logic               gie_q;

  always_comb begin
    src_evt          = '0;
    src_evt[SRC_NVM] = nvm_write_done;
    for (int t = 0; t < NUM_TMR; t++) begin
      src_evt[SRC_TMR_A + 2 * t] = tmr_match_a[t];
      src_evt[SRC_TMR_P + 2 * t] = tmr_match_p[t];
    end
  end

  // service never clears a source flag, only a write does
  gwl_flag_bank #(
    .W (SRC_W)
  ) u_src_flags (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .set_evt  (src_evt),
    .sw_we    (we_src_flag),
    .sw_wdata (hwdata[SRC_W-1:0]),
    .hw_clr   ('0),
    .flags    (src_flags),
    .rise     (src_rise)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      src_en_q <= SRC_RST;
      grp_en_q <= GRP_RST;
    end else begin
      if (we_src_en) begin
        src_en_q <= hwdata[SRC_W-1:0];
      end
      if (we_grp_en) begin
        grp_en_q <= hwdata[NUM_GRP-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // group request flags
  // ----------------------------------------------------------------
  always_comb begin
    for (int g = 0; g < NUM_GRP; g++) begin
      grp_set[g] = |(src_rise & src_en_q & grp_mask(g));
    end
  end

  gwl_flag_bank #(
    .W (NUM_GRP)
  ) u_grp_flags (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .set_evt  (grp_set),
    .sw_we    (we_grp_flag),
    .sw_wdata (hwdata[NUM_GRP-1:0]),
    .hw_clr   (grp_clr),
    .flags    (grp_flags),
    .rise     (grp_rise)
  );

  // ----------------------------------------------------------------
  // wake-up
  // ----------------------------------------------------------------
  // combinational from the event path, so it needs no running clock
  assign wake = (|src_rise) || (|grp_rise);

  // ----------------------------------------------------------------
  // arbitration and entry sequence
  // ----------------------------------------------------------------
  gwl_state_t         state_q;
  logic [CNT_W-1:0]   cnt_q;
  logic [NUM_GRP-1:0] pending;
  logic               take;
  logic [GRP_W-1:0]   take_grp;
  logic [GRP_W-1:0]   last_grp_q;
  logic [PC_W-1:0]    push_pc_q;
  logic [PC_W-1:0]    vector_q;

  assign pending  = grp_flags & grp_en_q;
  assign take     = (state_q == GWL_IDLE) && gie_q && (|pending) && !stack_full;
  assign take_grp = pick_lowest(pending);

  always_comb begin
    grp_clr = '0;
    if (take) begin
      grp_clr[take_grp] = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gie_q <= CTRL_GIE_RST;
    end else if (take) begin
      gie_q <= 1'b0;
    end else if (interrupt_exit) begin
      gie_q <= 1'b1;
    end else if (we_ctrl) begin
      gie_q <= hwdata[CTRL_GIE_BIT];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= GWL_IDLE;
      cnt_q   <= '0;
    end else begin
      unique case (state_q)
        GWL_IDLE: begin
          cnt_q <= '0;
          if (take) begin
            state_q <= GWL_ENTRY;
          end
        end
        GWL_ENTRY: begin
          cnt_q <= cnt_q + CNT_W'(1);
          if (cnt_q == CNT_W'(ENTRY_CLKS - 1)) begin
            state_q <= GWL_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      push_pc_q  <= '0;
      vector_q   <= PC_W'(VEC_GRP0);
      last_grp_q <= '0;
    end else if (take) begin
      push_pc_q  <= pc_value;
      vector_q   <= grp_vector(take_grp);
      last_grp_q <= take_grp;
    end
  end

  assign irq_busy    = (state_q == GWL_ENTRY);
  assign stack_push  = irq_busy && (cnt_q == '0);
  assign pc_load     = irq_busy && (cnt_q == CNT_W'(ENTRY_CLKS - 1));
  assign push_pc     = push_pc_q;
  assign vector_addr = vector_q;

  // ----------------------------------------------------------------
  // register read mux
  // ----------------------------------------------------------------
  always_comb begin
    rd_mux = '0;
    unique case (addr_q)
      ADDR_CTRL:     rd_mux[CTRL_GIE_BIT] = gie_q;
      ADDR_SRC_FLAG: rd_mux[SRC_W-1:0] = src_flags;
      ADDR_SRC_EN:   rd_mux[SRC_W-1:0] = src_en_q;
      ADDR_GRP_FLAG: rd_mux[NUM_GRP-1:0] = grp_flags;
      ADDR_GRP_EN:   rd_mux[NUM_GRP-1:0] = grp_en_q;
      ADDR_STATUS: begin
        rd_mux[STAT_BUSY_BIT] = irq_busy;
        rd_mux[STAT_GRP_LSB +: GRP_W] = last_grp_q;
      end
      default:       rd_mux = '0;
    endcase
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_entry_push;
    ##1 (stack_push && irq_busy);
  endsequence

  sequence s_entry_wait;
    (!pc_load && irq_busy) [*6];
  endsequence

  a_nvm_flag_set: assert property (nvm_write_done |=> src_flags[SRC_NVM])
    else $error("nvm write completion did not set its flag");

  a_take_gating: assert property ($rose(irq_busy)
                                  |-> $past(gie_q) && !$past(stack_full) && (|$past(pending)))
    else $error("vector taken without all enables or with stack full");

  a_take_clears_gie: assert property (take |=> !gie_q && irq_busy)
    else $error("global enable not cleared on entry");

  a_grp_flag_clear: assert property ((take && !grp_set[take_grp] && !we_grp_flag)
                                     |=> !grp_flags[$past(take_grp)])
    else $error("serviced group flag still set");

  a_tmr_flag_set: assert property ((src_evt != '0)
                                   |=> ((src_flags & $past(src_evt)) == $past(src_evt)))
    else $error("match event did not set its flag");

  a_src_flag_hold: assert property (!we_src_flag
                                    |=> ((src_flags & $past(src_flags)) == $past(src_flags)))
    else $error("source flag dropped without a software write");

  a_wake_on_rise: assert property ((|(src_flags & ~$past(src_flags))) |-> $past(wake))
    else $error("flag rose without a wake-up");

  a_push_pc_only: assert property (take |-> s_entry_push ##0 (push_pc == $past(pc_value)))
    else $error("pushed value is not the interrupted pc");

  a_entry_length: assert property (take |-> s_entry_push ##1 s_entry_wait ##1 pc_load)
    else $error("entry sequence not two instruction cycles");

  a_exit_sets_gie: assert property ((interrupt_exit && !take) |=> gie_q)
    else $error("interrupt exit did not set global enable");

  a_ret_keeps_gie: assert property ((subroutine_exit && !interrupt_exit && !take && !we_ctrl)
                                    |=> (gie_q == $past(gie_q)))
    else $error("subroutine exit changed global enable");

  a_lowest_first: assert property ((take && pending[0]) |=> (vector_addr == PC_W'(VEC_GRP0)))
    else $error("lowest vector group not served first");

endmodule

`default_nettype wire

// ---- inc/gwl_pkg.sv ----
// constants and types shared by the grouped interrupt and wake-up block
`default_nettype none

package gwl_pkg;

  // ----------------------------------------------------------------
  // source and group layout
  // ----------------------------------------------------------------
  localparam int NUM_TMR = 4;
  localparam int SRC_W   = 1 + 2 * NUM_TMR;
  localparam int NUM_GRP = 3;
  localparam int GRP_W   = 2;

  localparam int SRC_NVM   = 0;
  localparam int SRC_TMR_A = 1;
  localparam int SRC_TMR_P = 2;

  // which source flags feed each group request flag
  localparam logic [SRC_W-1:0] GRP0_MASK = 9'h001;
  localparam logic [SRC_W-1:0] GRP1_MASK = 9'h006;
  localparam logic [SRC_W-1:0] GRP2_MASK = 9'h1F8;

  // vector address of each group, lowest first
  localparam int VEC_GRP0 = 32'h0000_0010;
  localparam int VEC_GRP1 = 32'h0000_0014;
  localparam int VEC_GRP2 = 32'h0000_0018;

  // ----------------------------------------------------------------
  // register map, byte addresses
  // ----------------------------------------------------------------
  localparam int REG_AW = 8;
  localparam logic [REG_AW-1:0] ADDR_CTRL     = 8'h00;
  localparam logic [REG_AW-1:0] ADDR_SRC_FLAG = 8'h04;
  localparam logic [REG_AW-1:0] ADDR_SRC_EN   = 8'h08;
  localparam logic [REG_AW-1:0] ADDR_GRP_FLAG = 8'h0C;
  localparam logic [REG_AW-1:0] ADDR_GRP_EN   = 8'h10;
  localparam logic [REG_AW-1:0] ADDR_STATUS   = 8'h14;

  localparam int CTRL_GIE_BIT    = 0;
  localparam int STAT_BUSY_BIT   = 0;
  localparam int STAT_GRP_LSB    = 4;
  localparam logic CTRL_GIE_RST  = 1'b0;
  localparam logic [SRC_W-1:0]   SRC_RST = 9'h000;
  localparam logic [NUM_GRP-1:0] GRP_RST = 3'h0;

  localparam logic HRESP_OKAY = 1'b0;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PER_INSTR = 4;
  localparam int ENTRY_INSTR   = 2;
  localparam int ENTRY_CLKS    = ENTRY_INSTR * CLK_PER_INSTR;
  localparam int CNT_W         = 3;

  typedef enum logic {GWL_IDLE, GWL_ENTRY} gwl_state_t;

endpackage

`default_nettype wire

// ---- hdl/gwl_flag_bank.sv ----
// sticky request flags with hardware set, software write and hardware clear
`timescale 1ns/10ps
`default_nettype none

module gwl_flag_bank #(
  parameter int W = 8
) (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic [W-1:0] set_evt,
  input  wire logic         sw_we,
  input  wire logic [W-1:0] sw_wdata,
  input  wire logic [W-1:0] hw_clr,
  output logic      [W-1:0] flags,
  output logic      [W-1:0] rise
);

  logic [W-1:0] flags_q;
  logic [W-1:0] flags_d;

  // a set event wins over a software or service clear in the same cycle
  always_comb begin
    flags_d = sw_we ? sw_wdata : flags_q;
    flags_d = flags_d & ~hw_clr;
    flags_d = flags_d | set_evt;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags_q <= '0;
    end else begin
      flags_q <= flags_d;
    end
  end

  assign flags = flags_q;
  // low-to-high change, seen before the edge that stores it
  assign rise  = flags_d & ~flags_q;

endmodule

`default_nettype wire

// ---- bench/gwl_core_model.sv ----
// processor core sequencer and return stack facing the interrupt block
`timescale 1ns/10ps
`default_nettype none

module gwl_core_model #(
  parameter int PC_W  = 14,
  parameter int DEPTH = 8
) (
  input  wire logic            hclk,
  input  wire logic            hresetn,
  input  wire logic            stack_push,
  input  wire logic [PC_W-1:0] push_pc,
  input  wire logic            pc_load,
  input  wire logic [PC_W-1:0] vector_addr,
  input  wire logic            call_req,
  input  wire logic            interrupt_exit_req,
  input  wire logic            ret_req,
  output logic      [PC_W-1:0] pc_value,
  output logic                 stack_full,
  output logic                 interrupt_exit,
  output logic                 subroutine_exit,
  output int                   depth
);
  logic [PC_W-1:0] stk [DEPTH];

  // calls made by a handler eat the same levels the entry needs
  assign stack_full      = (depth == DEPTH);
  assign interrupt_exit  = interrupt_exit_req;
  assign subroutine_exit = ret_req;

  // only the pc goes on the stack, the handler keeps its own context
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pc_value <= '0;
      depth    <= 0;
    end else if (stack_push || call_req) begin
      stk[depth] <= stack_push ? push_pc : pc_value;
      depth      <= depth + 1;
      pc_value   <= pc_value + PC_W'(1);
    end else if ((interrupt_exit_req || ret_req) && depth > 0) begin
      pc_value <= stk[depth-1];
      depth    <= depth - 1;
    end else if (pc_load) begin
      pc_value <= vector_addr;
    end else begin
      pc_value <= pc_value + PC_W'(1);
    end
  end
endmodule

`default_nettype wire

// ---- bench/tb_grouped_interrupt_wakeup_logic.sv ----
// self-checking bench of the grouped interrupt and wake-up block
`timescale 1ns/10ps
`default_nettype none

module tb_grouped_interrupt_wakeup_logic;
  import gwl_pkg::*;

  localparam int PC_W = 14;
  logic               hclk = 1'b0;
  logic               hresetn = 1'b0;
  logic               hsel = 1'b0;
  logic               hwrite = 1'b0;
  logic [1:0]         htrans = 2'h0;
  logic [2:0]         hsize = 3'h2;
  logic [31:0]        haddr = 32'h0;
  logic [31:0]        hwdata = 32'h0;
  logic               nvm_write_done = 1'b0;
  logic [NUM_TMR-1:0] tmr_match_a = 4'h0;
  logic [NUM_TMR-1:0] tmr_match_p = 4'h0;
  logic               call_req = 1'b0;
  logic               interrupt_exit_req = 1'b0;
  logic               ret_req = 1'b0;
  logic [31:0]        hrdata;
  logic               hreadyout;
  logic               hresp;
  logic [PC_W-1:0]    pc_value;
  logic [PC_W-1:0]    push_pc;
  logic [PC_W-1:0]    vector_addr;
  logic               stack_full;
  logic               interrupt_exit;
  logic               subroutine_exit;
  logic               stack_push;
  logic               pc_load;
  logic               irq_busy;
  logic               wake;
  int                 depth;
  int                 n_mismatch = 0;
  int                 n_compared = 0;

  always #2.5 hclk = ~hclk;

  gwl_irq_ctrl #(.PC_W(PC_W)) dut_u (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .pc_value, .stack_full,
    .interrupt_exit, .subroutine_exit, .nvm_write_done, .tmr_match_a,
    .tmr_match_p, .stack_push, .push_pc, .pc_load, .vector_addr, .irq_busy, .wake
  );

  gwl_core_model #(.PC_W(PC_W), .DEPTH(8)) core_u (
    .hclk, .hresetn, .stack_push, .push_pc, .pc_load, .vector_addr, .call_req,
    .interrupt_exit_req, .ret_req, .pc_value, .stack_full, .interrupt_exit,
    .subroutine_exit, .depth
  );

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp, input string s);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: %s got %h expected %h", $time, s, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string s);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: %s got %b expected %b", $time, s, got, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    // hready is read at the rising edge, before that edge updates it
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk_bit(hresp, HRESP_OKAY, "response");
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string s);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk_reg(r, exp, s);
  endtask

  task automatic evt(input logic nvm, input logic [3:0] a, input logic [3:0] p, input logic w);
    @(posedge hclk);
    nvm_write_done <= nvm;
    tmr_match_a    <= a;
    tmr_match_p    <= p;
    @(negedge hclk);
    chk_bit(wake, w, "wake");
    @(posedge hclk);
    nvm_write_done <= 1'b0;
    tmr_match_a    <= 4'h0;
    tmr_match_p    <= 4'h0;
  endtask

  task automatic core(input logic c, input logic ri, input logic rs);
    @(posedge hclk);
    call_req <= c;
    interrupt_exit_req <= ri;
    ret_req  <= rs;
    @(posedge hclk);
    call_req <= 1'b0;
    interrupt_exit_req <= 1'b0;
    ret_req  <= 1'b0;
  endtask

  task automatic entry(input int vec);
    int n;
    n = 0;
    do begin @(negedge hclk); n++; end while (stack_push !== 1'b1 && n < 40);
    chk_bit(stack_push, 1'b1, "entry start");
    chk_reg(32'(push_pc), 32'(pc_value - 14'h0001), "pushed pc");
    n = 0;
    do begin @(negedge hclk); n++; end while (pc_load !== 1'b1 && n < 40);
    chk_reg(32'(n), 32'(ENTRY_CLKS - 1), "entry length");
    chk_reg(32'(vector_addr), vec, "vector");
  endtask

  task automatic quiet();
    logic bad;
    bad = 1'b0;
    repeat (20) begin
      @(negedge hclk);
      if (irq_busy !== 1'b0) bad = 1'b1;
    end
    chk_bit(bad, 1'b0, "blocked entry");
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    evt(1'b1, 4'h0, 4'h0, 1'b1);
    @(posedge hclk);
    hresetn <= 1'b1;
    for (int a = 0; a <= 24; a += 4) rd_chk(8'(a), 32'h0, "reset value");
    evt(1'b1, 4'h0, 4'h0, 1'b1);
    rd_chk(ADDR_SRC_FLAG, 32'h1, "nvm flag");
    rd_chk(ADDR_GRP_FLAG, 32'h0, "group flag");
    evt(1'b1, 4'h0, 4'h0, 1'b0);
    for (int k = 0; k < NUM_TMR; k++) begin
      evt(1'b0, 4'(1 << k), 4'h0, 1'b1);
      evt(1'b0, 4'h0, 4'(1 << k), 1'b1);
    end
    rd_chk(ADDR_SRC_FLAG, 32'h1FF, "all flags");
    wr(ADDR_SRC_FLAG, 32'h0);
    rd_chk(ADDR_SRC_FLAG, 32'h0, "flags cleared");
    wr(ADDR_SRC_EN, 32'h1FF);
    wr(ADDR_GRP_EN, 32'h7);
    evt(1'b1, 4'h0, 4'h0, 1'b1);
    rd_chk(ADDR_GRP_FLAG, 32'h1, "nvm group");
    quiet();
    wr(ADDR_CTRL, 32'h1);
    entry(VEC_GRP0);
    chk_reg(32'(depth), 32'h1, "stack depth");
    rd_chk(ADDR_CTRL, 32'h0, "gie after entry");
    rd_chk(ADDR_GRP_FLAG, 32'h0, "group after entry");
    rd_chk(ADDR_SRC_FLAG, 32'h1, "source kept");
    core(1'b0, 1'b1, 1'b0);
    rd_chk(ADDR_CTRL, 32'h1, "gie after exit");
    chk_reg(32'(depth), 32'h0, "stack depth");
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_SRC_FLAG, 32'h0);
    evt(1'b0, 4'h1, 4'h8, 1'b1);
    rd_chk(ADDR_GRP_FLAG, 32'h6, "timer groups");
    wr(ADDR_CTRL, 32'h1);
    entry(VEC_GRP1);
    rd_chk(ADDR_GRP_FLAG, 32'h4, "only served group");
    rd_chk(ADDR_SRC_FLAG, 32'h102, "timer sources kept");
    rd_chk(ADDR_STATUS, 32'h10, "last group");
    core(1'b0, 1'b0, 1'b1);
    rd_chk(ADDR_CTRL, 32'h0, "gie after plain exit");
    quiet();
    wr(ADDR_CTRL, 32'h1);
    entry(VEC_GRP2);
    core(1'b0, 1'b1, 1'b0);
    wr(ADDR_CTRL, 32'h0);
    repeat (8) core(1'b1, 1'b0, 1'b0);
    @(negedge hclk);
    chk_bit(stack_full, 1'b1, "stack full");
    wr(ADDR_SRC_FLAG, 32'h0);
    evt(1'b1, 4'h0, 4'h0, 1'b1);
    wr(ADDR_CTRL, 32'h1);
    quiet();
    core(1'b0, 1'b0, 1'b1);
    entry(VEC_GRP0);
    end_sim();
  end

  initial begin
    #50000;
    n_mismatch++;
    $display("unexpected at %0t: run did not finish", $time);
    end_sim();
  end
endmodule

`default_nettype wire
